// >>> dv/csdm_checker.sv
`timescale 1ns/1ps
`default_nettype none
module csdm_checker #(
	parameter int unsigned MIN_RUN_CYC = 20
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire csdm_pkg::csdm_cpu_stat_t cpu_stat,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	input wire csdm_pkg::csdm_mem_req_t mem_req,
	input wire logic cust_meter_on,
	input wire logic maint_meter_on,
	input wire logic system_light,
	input wire logic [15:0] indicators
);
	import csdm_pkg::*;
	logic [31:0] on_cnt_r;
	logic [31:0] on_cnt_nxt;
	logic run;
	logic on;
	assign run = (cpu_stat.clock_run & ~cpu_stat.wait_state & ~cpu_stat.soft_stop)
		| (~cpu_stat.hard_stop & ((|cpu_stat.chan_meter_in) | (|cpu_stat.file_selected)));
	assign on = cust_meter_on | maint_meter_on;
	always_comb on_cnt_nxt = on ? on_cnt_r + 32'h0000_0001 : 32'h0000_0000;
	always_ff @(posedge clk or posedge rst) if (rst) on_cnt_r <= '0; else on_cnt_r <= on_cnt_nxt;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_req_wait;
		mem_req.valid && !mem_ack;
	endsequence
	sequence s_ack_read;
		mem_ack && !mem_req.write;
	endsequence
	sequence s_run_gone;
		!run [*3] ##0 on_cnt_r > MIN_RUN_CYC + 3;
	endsequence
	a_pready_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
	a_pready_pulse: assert property (pready |=> !pready) else $error("pready held");
	a_slverr_map: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08,
		8'h0c, 8'h10})) else $error("pslverr wrong");
	a_meter_excl: assert property (!(cust_meter_on && maint_meter_on)) else $error("two meters");
	a_meter_start: assert property (run |=> on) else $error("meter not started");
	a_meter_idle: assert property (!run && !on |=> !on) else $error("meter ran idle");
	a_meter_hold: assert property ($fell(on) |-> on_cnt_r >= MIN_RUN_CYC) else $error("short run");
	a_meter_stop: assert property (s_run_gone |=> !on) else $error("meter kept on");
	a_light_on: assert property (on |=> system_light) else $error("light off");
	a_req_hold: assert property (s_req_wait |=> $stable(mem_req)) else $error("request moved");
	a_ack_drop: assert property (mem_ack |=> !mem_req.valid) else $error("valid stuck");
	a_show_read: assert property (s_ack_read |=> indicators == $past(mem_rdata))
		else $error("display data wrong");
	a_show_write: assert property (mem_ack && mem_req.write |=> indicators == $past(mem_req.wdata))
		else $error("stored data not shown");
	a_store_gate: assert property ($rose(mem_req.valid) && mem_req.write |-> $past(cpu_stat.manual)
		&& $past(cpu_stat.allow_manual)) else $error("store not allowed");
	a_aux_addr: assert property ($rose(mem_req.valid) && mem_req.aux |-> mem_req.addr[15:12] == 4'h0)
		else $error("aux address wrong");
	a_half_align: assert property (mem_req.valid |-> !mem_req.addr[0]) else $error("odd address");
endmodule : csdm_checker
bind csdm_top csdm_checker #(.MIN_RUN_CYC(MIN_RUN_CYC)) csdm_checker_i (.clk(clk), .rst(rst),
	.psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.cpu_stat(cpu_stat), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_req(mem_req),
	.cust_meter_on(cust_meter_on), .maint_meter_on(maint_meter_on),
	.system_light(system_light), .indicators(indicators));
`default_nettype wire

// >>> dv/csdm_store_model.sv
`timescale 1ns/1ps
`default_nettype none
module csdm_store_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] delay,
	input wire csdm_pkg::csdm_mem_req_t mem_req,
	output logic mem_ack,
	output logic [15:0] mem_rdata
);
	import csdm_pkg::*;
	logic [15:0] mem [logic [16:0]];
	logic [16:0] k;
	logic [3:0] cnt;
	assign k = {mem_req.aux, mem_req.addr};
	// Data lines toggle when idle so a stale word is never mistaken for an answer
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_ack <= 1'b0;
			cnt <= 4'h0;
			mem_rdata <= 16'h0000;
		end else if (mem_ack || !mem_req.valid || cnt < delay) begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req.valid && !mem_ack) cnt <= cnt + 4'h1;
		end else begin
			cnt <= 4'h0;
			mem_ack <= 1'b1;
			if (mem_req.write) mem[k] = mem_req.wdata;
			mem_rdata <= mem.exists(k) ? mem[k] : mem_req.addr ^ 16'h5a5a;
		end
	end
endmodule : csdm_store_model
`default_nettype wire

// >>> dv/test_console_store_display_meter.sv
`timescale 1ns/1ps
`default_nettype none
module test_console_store_display_meter;
	import csdm_pkg::*;
	typedef struct {logic [15:0] m; logic [15:0] a; logic [15:0] e;} csdm_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rq;
	logic pready, pslverr, re, mem_ack, cpu_stop_req, cust_meter_on, maint_meter_on, system_light;
	logic cpu_start_pulse;
	logic [15:0] mem_rdata, indicators;
	logic [3:0] delay = 4'h0;
	csdm_cpu_stat_t stat = '0;
	csdm_mem_req_t mem_req;
	int n_fail = 0;
	int n_tests = 0;
	int n_start = 0;
	// Control word per row: mode in [2:0], installed size in [5:4]
	csdm_row_t rows[19] = '{'{16'h0000, 16'h0010, 16'h5a4a}, '{16'h0000, 16'h0011, 16'h5a4a},
		'{16'h0000, 16'h3ffe, 16'h65a4}, '{16'h0000, 16'h8000, 16'h65a4},
		'{16'h0000, 16'h4000, 16'h1a5a}, '{16'h0001, 16'h7b42, 16'h5d18},
		'{16'h0001, 16'h8100, 16'h5d18}, '{16'h0020, 16'h7ffe, 16'h25a4},
		'{16'h0020, 16'h8000, 16'hda5a}, '{16'h0020, 16'hc000, 16'hda5a},
		'{16'h0011, 16'h9100, 16'h535a}, '{16'h0011, 16'h6100, 16'h535a},
		'{16'h0030, 16'hc000, 16'h9a5a}, '{16'h0002, 16'h0000, 16'h1111},
		'{16'h0003, 16'h0000, 16'h2222}, '{16'h0004, 16'h0000, 16'h3333},
		'{16'h0005, 16'h0000, 16'h4444}, '{16'h0006, 16'h0000, 16'h5555},
		'{16'h0007, 16'h0000, 16'h5555}};
	csdm_top #(.MIN_RUN_CYC(20)) csdm_top_i (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cpu_stat(stat),
		.cpu_regs(80'h1111_2222_3333_4444_5555), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.mem_req(mem_req), .cpu_stop_req(cpu_stop_req), .cpu_start_pulse(cpu_start_pulse),
		.cust_meter_on(cust_meter_on), .maint_meter_on(maint_meter_on),
		.system_light(system_light), .indicators(indicators));
	csdm_store_model csdm_store_model_i (.clk(clk), .rst(rst), .delay(delay),
		.mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	always #5 clk = ~clk;
	// The start pulse stands one cycle only, so it is counted where it stands
	always @(posedge clk) begin
		if (cpu_start_pulse === 1'b1) n_start++;
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic finish_test;
		if (n_fail == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : finish_test
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (n >= 50) n_fail++;
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, {16'h0000, d});
	endtask : wr
	// Waits on the busy flag so every storage answer has landed before a check
	task automatic key(input logic [4:0] k);
		int n;
		n = 0;
		wr(8'h0c, {11'h000, k});
		rq = 32'h0020_0000;
		while (rq[21] && n < 30) begin
			apb(1'b0, 8'h10, 32'h0000_0000);
			n++;
		end
		if (n >= 30) n_fail++;
	endtask : key
	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		finish_test;
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		chk("reset", 32'h0000_0000, {indicators, cpu_stop_req, cust_meter_on, maint_meter_on});
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk("slverr", 32'h0000_0001, re);
		wr(8'h04, 16'h0010);
		key(5'h04);
		chk("ind", 32'h0000_0000, indicators);
		key(5'h01);
		chk("stop", 32'h0000_0001, cpu_stop_req);
		stat.manual <= 1'b1;
		stat.allow_manual <= 1'b1;
		foreach (rows[i]) begin
			wr(8'h00, rows[i].m);
			wr(8'h04, rows[i].a);
			key(5'h04);
			chk("row", rows[i].e, indicators);
		end
		delay <= 4'h5;
		wr(8'h00, 16'h0000);
		wr(8'h04, 16'h0100);
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk("addr", 32'h0000_0100, rq);
		key(5'h08);
		chk("ind", 32'h0000_5555, indicators);
		key(5'h04);
		chk("ind", 32'h0000_5b5a, indicators);
		wr(8'h08, 16'hbeef);
		stat.allow_manual <= 1'b0;
		key(5'h08);
		chk("ind", 32'h0000_5b5a, indicators);
		stat.allow_manual <= 1'b1;
		key(5'h08);
		chk("ind", 32'h0000_beef, indicators);
		wr(8'h04, 16'h0102);
		key(5'h04);
		wr(8'h04, 16'h0100);
		key(5'h04);
		chk("ind", 32'h0000_beef, indicators);
		wr(8'h04, 16'h4002);
		key(5'h04);
		wr(8'h08, 16'h1234);
		key(5'h08);
		chk("ind", 32'h0000_1a58, indicators);
		wr(8'h00, 16'h0100);
		apb(1'b0, 8'h00, 32'h0000_0000);
		chk("ctrl", 32'h0000_0100, rq);
		key(5'h10);
		key(5'h04);
		key(5'h08);
		chk("ind", 32'h0000_1234, indicators);
		stat.file_selected <= 4'h1;
		repeat (2) @(posedge clk);
		stat.file_selected <= 4'h0;
		repeat (12) @(posedge clk);
		chk("meters", 32'h0000_0001, {cust_meter_on, maint_meter_on});
		chk("light", 32'h0000_0001, system_light);
		repeat (20) @(posedge clk);
		chk("meters", 32'h0000_0000, {cust_meter_on, maint_meter_on});
		wr(8'h00, 16'h0000);
		stat.hard_stop <= 1'b1;
		stat.chan_meter_in <= 4'h8;
		repeat (5) @(posedge clk);
		chk("meters", 32'h0000_0000, {cust_meter_on, maint_meter_on});
		stat.hard_stop <= 1'b0;
		stat.chan_meter_in <= 4'h0;
		stat.clock_run <= 1'b1;
		stat.wait_state <= 1'b1;
		repeat (5) @(posedge clk);
		chk("meters", 32'h0000_0000, {cust_meter_on, maint_meter_on});
		stat.wait_state <= 1'b0;
		repeat (3) @(posedge clk);
		chk("meters", 32'h0000_0002, {cust_meter_on, maint_meter_on});
		stat.clock_run <= 1'b0;
		repeat (30) @(posedge clk);
		chk("meters", 32'h0000_0000, {cust_meter_on, maint_meter_on});
		chk("start", 32'h0000_0000, n_start);
		key(5'h02);
		chk("stop", 32'h0000_0000, cpu_stop_req);
		chk("start", 32'h0000_0001, n_start);
		finish_test;
	end
endmodule : test_console_store_display_meter
`default_nettype wire

// >>> logic/csdm_defines.svh
`ifndef CSDM_DEFINES_SVH
`define CSDM_DEFINES_SVH

`define CSDM_OFS_CTRL 8'h00
`define CSDM_OFS_ADDR 8'h04
`define CSDM_OFS_DATA 8'h08
`define CSDM_OFS_KEYS 8'h0c
`define CSDM_OFS_STAT 8'h10

`define CSDM_CTRL_MODE_LSB 0
`define CSDM_CTRL_SIZE_LSB 4
`define CSDM_CTRL_MAINT_BIT 8

`define CSDM_KEY_STOP 0
`define CSDM_KEY_START 1
`define CSDM_KEY_DISPLAY 2
`define CSDM_KEY_STORE 3
`define CSDM_KEY_CS_EN 4

`define CSDM_PROG_TOP_16K 16'h3fff
`define CSDM_PROG_TOP_24K 16'h5fff
`define CSDM_PROG_TOP_32K 16'h7fff
`define CSDM_PROG_TOP_48K 16'hbfff
`define CSDM_CS_BASE_16K 16'h4000
`define CSDM_CS_TOP_16K 16'h7fff
`define CSDM_CS_BASE_32K 16'h8000
`define CSDM_CS_TOP_32K 16'hbfff
`define CSDM_CS_BASE_48K 16'hc000
`define CSDM_CS_TOP_48K 16'hffff

`define CSDM_CLK_MHZ 100
`define CSDM_MIN_RUN_MS 400
`define CSDM_MIN_RUN_CYC (`CSDM_MIN_RUN_MS * 1000 * `CSDM_CLK_MHZ)
`define CSDM_TMR_W 26

`endif

// >>> logic/csdm_min_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "csdm_defines.svh"

module csdm_min_timer #(
	parameter int unsigned MIN_CYC = `CSDM_MIN_RUN_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run_i,
	output logic on_o
);
	logic [`CSDM_TMR_W-1:0] cnt_r;
	logic [`CSDM_TMR_W-1:0] cnt_nxt;
	logic on_r;
	logic on_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		if (run_i && !on_r) begin
			cnt_nxt = `CSDM_TMR_W'(MIN_CYC);
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - `CSDM_TMR_W'(1);
		end
		// Off only when neither the request nor the hold time remains
		on_nxt = run_i || (cnt_nxt != '0);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			on_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			on_r <= on_nxt;
		end
	end

	assign on_o = on_r;

endmodule : csdm_min_timer
`default_nettype wire

// >>> logic/csdm_pkg.sv
package csdm_pkg;

	typedef enum logic [2:0] {
		main_storage_view = 3'h0,
		aux_storage_view = 3'h1,
		modifier_local_view = 3'h2,
		logic_unit_external_view = 3'h3,
		ctrl_reg_view = 3'h4,
		operand_view = 3'h5,
		addr_backup_view = 3'h6
	} csdm_mode_t;

	typedef enum logic [1:0] {
		size_16k = 2'h0,
		size_24k = 2'h1,
		size_32k = 2'h2,
		size_48k = 2'h3
	} csdm_size_t;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_read = 2'b01,
		st_write = 2'b10
	} csdm_state_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic aux;
		logic [15:0] addr;
		logic [15:0] wdata;
	} csdm_mem_req_t;

	typedef struct packed {
		logic [15:0] modifier_local;
		logic [15:0] logic_unit_ext;
		logic [15:0] ctrl_reg;
		logic [15:0] operand;
		logic [15:0] addr_backup;
	} csdm_cpu_regs_t;

	typedef struct packed {
		logic clock_run;
		logic wait_state;
		logic soft_stop;
		logic hard_stop;
		logic manual;
		logic allow_manual;
		logic [3:0] chan_meter_in;
		logic [3:0] file_selected;
	} csdm_cpu_stat_t;

endpackage : csdm_pkg

// >>> logic/csdm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "csdm_defines.svh"

module csdm_top #(
	parameter int unsigned MIN_RUN_CYC = `CSDM_MIN_RUN_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire csdm_pkg::csdm_cpu_stat_t cpu_stat,
	input wire csdm_pkg::csdm_cpu_regs_t cpu_regs,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	output csdm_pkg::csdm_mem_req_t mem_req,
	output logic cpu_stop_req,
	output logic cpu_start_pulse,
	output logic cust_meter_on,
	output logic maint_meter_on,
	output logic system_light,
	output logic [15:0] indicators
);
	import csdm_pkg::*;

	function automatic logic prog_ok(input csdm_size_t sz, input logic [15:0] a);
		logic ok;
		ok = 1'b0;
		unique case (sz)
			size_16k: ok = (a <= `CSDM_PROG_TOP_16K);
			size_24k: ok = (a <= `CSDM_PROG_TOP_24K);
			size_32k: ok = (a <= `CSDM_PROG_TOP_32K);
			size_48k: ok = (a <= `CSDM_PROG_TOP_48K);
		endcase
		return ok;
	endfunction : prog_ok

	function automatic logic cs_ok(input csdm_size_t sz, input logic [15:0] a);
		logic ok;
		ok = 1'b0;
		unique case (sz)
			size_16k: ok = (a >= `CSDM_CS_BASE_16K) && (a <= `CSDM_CS_TOP_16K);
			size_24k, size_32k: ok = (a >= `CSDM_CS_BASE_32K) && (a <= `CSDM_CS_TOP_32K);
			size_48k: ok = (a >= `CSDM_CS_BASE_48K);
		endcase
		return ok;
	endfunction : cs_ok

	// High digit of an aux address, switch A
	function automatic logic aux_ok(input csdm_size_t sz, input logic [3:0] d);
		logic ok;
		ok = 1'b0;
		unique case (sz)
			size_16k: ok = (d <= 4'h7);
			size_24k: ok = (d <= 4'h5) || ((d >= 4'h8) && (d <= 4'hb));
			size_32k: ok = (d <= 4'hb);
			size_48k: ok = 1'b1;
		endcase
		return ok;
	endfunction : aux_ok

	// Bus slave state
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pready_r;
	logic pready_nxt;
	logic pslverr_r;
	logic pslverr_nxt;

	// Panel and storage access state
	csdm_mode_t mode_r;
	csdm_mode_t mode_nxt;
	csdm_size_t size_r;
	csdm_size_t size_nxt;
	logic maint_r;
	logic maint_nxt;
	logic [15:0] addr_sw_r;
	logic [15:0] addr_sw_nxt;
	logic [15:0] data_sw_r;
	logic [15:0] data_sw_nxt;
	logic cs_en_r;
	logic cs_en_nxt;
	logic armed_r;
	logic armed_nxt;
	logic tgt_aux_r;
	logic tgt_aux_nxt;
	logic tgt_cs_r;
	logic tgt_cs_nxt;
	logic [15:0] tgt_addr_r;
	logic [15:0] tgt_addr_nxt;
	logic [15:0] ind_r;
	logic [15:0] ind_nxt;
	logic reject_r;
	logic reject_nxt;
	csdm_state_t state_r;
	csdm_state_t state_nxt;
	csdm_mem_req_t mreq_r;
	csdm_mem_req_t mreq_nxt;
	logic stop_r;
	logic stop_nxt;
	logic start_r;
	logic start_nxt;

	// Meter state
	logic run_any;
	logic cust_on;
	logic maint_on;
	logic sys_light_r;
	logic sys_light_nxt;

	logic access;
	logic wr_fire;
	logic hit;
	logic [4:0] keys;
	logic [31:0] rd_val;
	logic [15:0] aux_addr;

	assign access = psel && penable;
	assign wr_fire = access && pready_r && pwrite;
	assign keys = (wr_fire && paddr == `CSDM_OFS_KEYS) ? pwdata[4:0] : 5'h00;
	assign aux_addr = {4'h0, addr_sw_r[15:12], addr_sw_r[7:0]};

	always_comb begin
		hit = 1'b1;
		rd_val = 32'h0000_0000;
		unique case (paddr)
			`CSDM_OFS_CTRL: begin
				rd_val[`CSDM_CTRL_MODE_LSB +: 3] = mode_r;
				rd_val[`CSDM_CTRL_SIZE_LSB +: 2] = size_r;
				rd_val[`CSDM_CTRL_MAINT_BIT] = maint_r;
			end
			`CSDM_OFS_ADDR: rd_val[15:0] = addr_sw_r;
			`CSDM_OFS_DATA: rd_val[15:0] = data_sw_r;
			`CSDM_OFS_KEYS: rd_val = 32'h0000_0000;
			`CSDM_OFS_STAT: begin
				rd_val = {7'h00, reject_r, cs_en_r, armed_r, (state_r != st_idle),
					maint_on, cust_on, sys_light_r, cpu_stat.allow_manual,
					cpu_stat.manual, ind_r};
			end
			default: hit = 1'b0;
		endcase
		pready_nxt = access && !pready_r;
		prdata_nxt = 32'h0000_0000;
		pslverr_nxt = 1'b0;
		if (access && !pready_r) begin
			prdata_nxt = pwrite ? 32'h0000_0000 : rd_val;
			pslverr_nxt = !hit;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	always_comb begin
		mode_nxt = mode_r;
		size_nxt = size_r;
		maint_nxt = maint_r;
		addr_sw_nxt = addr_sw_r;
		data_sw_nxt = data_sw_r;
		cs_en_nxt = cs_en_r;
		armed_nxt = armed_r;
		tgt_aux_nxt = tgt_aux_r;
		tgt_cs_nxt = tgt_cs_r;
		tgt_addr_nxt = tgt_addr_r;
		ind_nxt = ind_r;
		reject_nxt = reject_r;
		state_nxt = state_r;
		mreq_nxt = mreq_r;
		stop_nxt = stop_r;
		start_nxt = 1'b0;

		if (wr_fire && paddr == `CSDM_OFS_CTRL) begin
			mode_nxt = csdm_mode_t'(pwdata[`CSDM_CTRL_MODE_LSB +: 3]);
			size_nxt = csdm_size_t'(pwdata[`CSDM_CTRL_SIZE_LSB +: 2]);
			maint_nxt = pwdata[`CSDM_CTRL_MAINT_BIT];
			if (mode_nxt != mode_r) begin
				armed_nxt = 1'b0;
			end
		end
		if (wr_fire && paddr == `CSDM_OFS_ADDR) begin
			addr_sw_nxt = pwdata[15:0];
			if (pwdata[15:0] != addr_sw_r) begin
				armed_nxt = 1'b0;
			end
		end
		if (wr_fire && paddr == `CSDM_OFS_DATA) begin
			data_sw_nxt = pwdata[15:0];
		end

		// Stop holds until start; the CPU answers with its manual level
		if (keys[`CSDM_KEY_STOP]) begin
			stop_nxt = 1'b1;
		end else if (keys[`CSDM_KEY_START]) begin
			stop_nxt = 1'b0;
			start_nxt = 1'b1;
		end

		if (!maint_nxt) begin
			cs_en_nxt = 1'b0;
		end else if (keys[`CSDM_KEY_CS_EN]) begin
			cs_en_nxt = 1'b1;
		end

		unique case (state_r)
			st_idle: begin
				if (keys[`CSDM_KEY_DISPLAY]) begin
					reject_nxt = 1'b0;
					armed_nxt = 1'b0;
					if (!cpu_stat.manual) begin
						reject_nxt = 1'b1;
					end else begin
						unique case (mode_r)
							main_storage_view: begin
								if (prog_ok(size_r, addr_sw_r) || cs_ok(size_r, addr_sw_r)) begin
									tgt_aux_nxt = 1'b0;
									tgt_cs_nxt = cs_ok(size_r, addr_sw_r);
									tgt_addr_nxt = {addr_sw_r[15:1], 1'b0};
									state_nxt = st_read;
								end else begin
									reject_nxt = 1'b1;
								end
							end
							aux_storage_view: begin
								if (aux_ok(size_r, addr_sw_r[15:12])) begin
									tgt_aux_nxt = 1'b1;
									tgt_cs_nxt = 1'b0;
									tgt_addr_nxt = {aux_addr[15:1], 1'b0};
									state_nxt = st_read;
								end else begin
									reject_nxt = 1'b1;
								end
							end
							modifier_local_view: ind_nxt = cpu_regs.modifier_local;
							logic_unit_external_view: ind_nxt = cpu_regs.logic_unit_ext;
							ctrl_reg_view: ind_nxt = cpu_regs.ctrl_reg;
							operand_view: ind_nxt = cpu_regs.operand;
							addr_backup_view: ind_nxt = cpu_regs.addr_backup;
							default: reject_nxt = 1'b1;
						endcase
					end
					if (state_nxt == st_read) begin
						mreq_nxt = '{valid: 1'b1, write: 1'b0, aux: tgt_aux_nxt,
							addr: tgt_addr_nxt, wdata: 16'h0000};
					end
				end else if (keys[`CSDM_KEY_STORE]) begin
					// Target is the location of the last display, not the switches
					if (armed_r && cpu_stat.manual && cpu_stat.allow_manual &&
						(!tgt_cs_r || (maint_r && cs_en_r))) begin
						reject_nxt = 1'b0;
						mreq_nxt = '{valid: 1'b1, write: 1'b1, aux: tgt_aux_r,
							addr: tgt_addr_r, wdata: data_sw_r};
						state_nxt = st_write;
					end else begin
						reject_nxt = 1'b1;
					end
				end
			end
			st_read: begin
				if (mem_ack) begin
					ind_nxt = mem_rdata;
					armed_nxt = 1'b1;
					mreq_nxt.valid = 1'b0;
					state_nxt = st_idle;
				end
			end
			st_write: begin
				if (mem_ack) begin
					ind_nxt = mreq_r.wdata;
					mreq_nxt.valid = 1'b0;
					state_nxt = st_idle;
				end
			end
			default: state_nxt = st_idle;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_r <= main_storage_view;
			size_r <= size_16k;
			maint_r <= 1'b0;
			addr_sw_r <= 16'h0000;
			data_sw_r <= 16'h0000;
			cs_en_r <= 1'b0;
			armed_r <= 1'b0;
			tgt_aux_r <= 1'b0;
			tgt_cs_r <= 1'b0;
			tgt_addr_r <= 16'h0000;
			ind_r <= 16'h0000;
			reject_r <= 1'b0;
			state_r <= st_idle;
			mreq_r <= '0;
			stop_r <= 1'b0;
			start_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			size_r <= size_nxt;
			maint_r <= maint_nxt;
			addr_sw_r <= addr_sw_nxt;
			data_sw_r <= data_sw_nxt;
			cs_en_r <= cs_en_nxt;
			armed_r <= armed_nxt;
			tgt_aux_r <= tgt_aux_nxt;
			tgt_cs_r <= tgt_cs_nxt;
			tgt_addr_r <= tgt_addr_nxt;
			ind_r <= ind_nxt;
			reject_r <= reject_nxt;
			state_r <= state_nxt;
			mreq_r <= mreq_nxt;
			stop_r <= stop_nxt;
			start_r <= start_nxt;
		end
	end

	// Channel and file activity count as use only when not hard-stopped
	always_comb begin
		run_any = (cpu_stat.clock_run && !cpu_stat.wait_state && !cpu_stat.soft_stop) ||
			(!cpu_stat.hard_stop &&
			((|cpu_stat.chan_meter_in) || (|cpu_stat.file_selected)));
		sys_light_nxt = run_any || cust_on || maint_on;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sys_light_r <= 1'b0;
		end else begin
			sys_light_r <= sys_light_nxt;
		end
	end

	// A key turn mid-run lets the old meter finish its hold before the other one starts
	csdm_min_timer #(
		.MIN_CYC(MIN_RUN_CYC)
	) u_cust_meter (
		.clk(clk),
		.rst(rst),
		.run_i(run_any && !maint_r && !maint_on),
		.on_o(cust_on)
	);

	csdm_min_timer #(
		.MIN_CYC(MIN_RUN_CYC)
	) u_maint_meter (
		.clk(clk),
		.rst(rst),
		.run_i(run_any && maint_r && !cust_on),
		.on_o(maint_on)
	);

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign mem_req = mreq_r;
	assign cpu_stop_req = stop_r;
	assign cpu_start_pulse = start_r;
	assign cust_meter_on = cust_on;
	assign maint_meter_on = maint_on;
	assign system_light = sys_light_r;
	assign indicators = ind_r;

endmodule : csdm_top
`default_nettype wire
